// >>> oam_status_counters.sv
// Purpose: maintenance status and packet counter register bank behind APB
// Assumes: pins are asynchronous and synchronised here; engine events are on clock
// Notes: role is a strap caught once its synchroniser holds the real pin level,
//        the third clock after reset release; until then the role reads centre
// Notes: interrupt status at index 0xF0 and mask at 0xF1, bits tx, rx, optical, utp
// Notes: apb has no wait states; read data is registered from the setup cycle
// Operation
// - count each valid transmitted maintenance packet not arriving in the same cycle as a clear
// - count only good received maintenance packets
// - writing zero to control clears counters
// - mirror partner status while optical link up
// - role bit six: terminal one, centre zero
// - bit five set in any loopback state
// - bit four: pin on terminal, software on centre
// - bit three diagnostic: pin terminal, software centre
// - bit two utp down, resets to one
// - bit one set when optical signal absent
// - second byte bit three multi interface, writable
// - autoneg bit: pin at strap then software on terminal, zero centre
// - duplex bit, zero if down or centre
// - speed bit, zero if down or centre
// - partner bytes share local status layout
`timescale 1ns/1ps
module oam_status_counters
(
	input  wire logic                          clock,
	input  wire logic                          nrst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          terminal_role_strap,
	input  wire oam_status_pkg::phy_pins_t     pins,
	input  wire oam_status_pkg::engine_events_t events,
	output logic                               irq
);
	oam_status_pkg::phy_pins_t pins_meta;
	oam_status_pkg::phy_pins_t pins_sync;
	logic                      strap_meta;
	logic                      strap_sync;
	logic                      strap_taken;
	logic                      terminal_role;
	logic                      next_terminal_role;
	logic                      next_strap_taken;
	oam_status_pkg::phy_pins_t next_pins_meta;
	oam_status_pkg::phy_pins_t next_pins_sync;
	logic                      next_strap_meta;
	logic                      next_strap_sync;

	// counts edges since release so the strap is only taken once it has crossed both flops
	logic [1:0]                strap_warm;
	logic [1:0]                next_strap_warm;

	logic [7:0] tx_count;
	logic [7:0] rx_count;
	logic [7:0] partner_mirror;
	logic       loss_select;
	logic       diag_result;
	logic       utp_down;
	logic       multi_if;
	logic       autoneg;
	logic [7:0] next_tx_count;
	logic [7:0] next_rx_count;
	logic [7:0] next_partner_mirror;
	logic       next_loss_select;
	logic       next_diag_result;
	logic       next_utp_down;
	logic       next_multi_if;
	logic       next_autoneg;

	logic [oam_status_pkg::irq_width-1:0] irq_status;
	logic [oam_status_pkg::irq_width-1:0] irq_mask;
	logic [oam_status_pkg::irq_width-1:0] next_irq_status;
	logic [oam_status_pkg::irq_width-1:0] next_irq_mask;
	logic [oam_status_pkg::irq_width-1:0] irq_events;
	logic                                 opt_prev;
	logic                                 utp_prev;
	logic                                 next_opt_prev;
	logic                                 next_utp_prev;
	logic                                 next_irq;

	logic [31:0] next_prdata;
	logic [7:0]  reg_index;
	logic        wr_access;
	logic        rd_access;
	logic        mapped;
	logic [7:0]  status_first;
	logic [7:0]  status_second;

	// two-flop synchronisers for all asynchronous inputs; only the second stage is read
	always_comb
	begin
		next_pins_meta  = pins;
		next_pins_sync  = pins_meta;
		next_strap_meta = terminal_role_strap;
		next_strap_sync = strap_meta;
		// strap_sync shows the real strap only from the second edge after release
		next_strap_warm = {strap_warm[0], 1'b1};
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pins_meta  <= '0;
			pins_sync  <= '0;
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
			strap_warm <= 2'b00;
		end
		else
		begin
			pins_meta  <= next_pins_meta;
			pins_sync  <= next_pins_sync;
			strap_meta <= next_strap_meta;
			strap_sync <= next_strap_sync;
			strap_warm <= next_strap_warm;
		end
	end

	assign reg_index = paddr[oam_status_pkg::addr_lsb +: 8];
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;
	assign pready    = 1'b1;

	always_comb
	begin
		mapped = 1'b1;
		case (reg_index)
			oam_status_pkg::idx_maint_ctrl,
			oam_status_pkg::idx_tx_count,
			oam_status_pkg::idx_rx_count,
			oam_status_pkg::idx_partner_mirror,
			oam_status_pkg::idx_status_first,
			oam_status_pkg::idx_status_second,
			oam_status_pkg::idx_irq_status,
			oam_status_pkg::idx_irq_mask: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		// byte lanes are not supported: only whole aligned words are accepted
		if (paddr[1:0] != 2'b00)
		begin
			mapped = 1'b0;
		end
	end

	assign pslverr = psel && penable && !mapped;

	// role and strap capture: strap is sampled once synchronised, then held
	// taking it earlier would latch the synchroniser's reset value, not the pin
	always_comb
	begin
		next_strap_taken   = strap_warm[1];
		next_terminal_role = strap_taken ? terminal_role : strap_sync;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			strap_taken   <= 1'b0;
			terminal_role <= 1'b0;
		end
		else
		begin
			strap_taken   <= next_strap_taken;
			terminal_role <= next_terminal_role;
		end
	end

	// live status composition
	always_comb
	begin
		status_first = 8'h00;
		status_first[oam_status_pkg::bit_role]        = terminal_role;
		status_first[oam_status_pkg::bit_loopback]    = events.loopback_active;
		status_first[oam_status_pkg::bit_loss_select] = loss_select;
		status_first[oam_status_pkg::bit_diag]        = diag_result;
		status_first[oam_status_pkg::bit_utp_down]    = utp_down;
		status_first[oam_status_pkg::bit_opt_absent]  = pins_sync.optical_signal_absent;

		status_second = 8'h00;
		status_second[oam_status_pkg::bit_multi_if] = multi_if;
		status_second[oam_status_pkg::bit_autoneg]  = terminal_role && autoneg;
		status_second[oam_status_pkg::bit_duplex]   =
			terminal_role && !utp_down && pins_sync.utp_full_duplex;
		status_second[oam_status_pkg::bit_speed]    =
			terminal_role && !utp_down && pins_sync.utp_speed_100;
	end

	// counters, mirror and writable status bits
	always_comb
	begin
		next_tx_count       = tx_count;
		next_rx_count       = rx_count;
		next_partner_mirror = partner_mirror;
		next_loss_select    = loss_select;
		next_diag_result    = diag_result;
		next_utp_down       = utp_down;
		next_multi_if       = multi_if;
		next_autoneg        = autoneg;

		// eight-bit adders wrap from 255 to zero on their own
		if (events.tx_valid_packet)
		begin
			next_tx_count = tx_count + 8'h01;
		end
		if (events.rx_valid_packet)
		begin
			next_rx_count = rx_count + 8'h01;
		end

		// a clear in the same cycle as a packet wins: that packet is lost
		if (wr_access && reg_index == oam_status_pkg::idx_maint_ctrl
			&& pwdata[7:0] == oam_status_pkg::count_clear_value)
		begin
			next_tx_count = oam_status_pkg::count_reset;
			next_rx_count = oam_status_pkg::count_reset;
		end

		// mirror takes its role-dependent reset value while the strap is being taken
		if (!strap_taken)
		begin
			next_partner_mirror = strap_sync ? oam_status_pkg::mirror_reset_terminal
				: oam_status_pkg::mirror_reset_centre;
		end
		else if (events.partner_update && !pins_sync.optical_signal_absent)
		begin
			next_partner_mirror = events.partner_status_byte;
		end

		// pin-owned bits: diag and autoneg start from the pins, then all but autoneg follow them in terminal role
		if (!strap_taken)
		begin
			next_diag_result = strap_sync && pins_sync.diagnostic_fail_pin;
			next_autoneg     = strap_sync && pins_sync.autoneg_enable_pin;
		end
		else if (terminal_role)
		begin
			next_loss_select = pins_sync.loss_select_pin;
			next_diag_result = pins_sync.diagnostic_fail_pin;
			next_utp_down    = pins_sync.utp_link_down;
		end

		// centre role: software owns loss_select, diag and utp_down; multi_if is writable in any role, autoneg in terminal role only
		if (wr_access && reg_index == oam_status_pkg::idx_status_first && strap_taken && !terminal_role)
		begin
			next_loss_select = pwdata[oam_status_pkg::bit_loss_select];
			next_diag_result = pwdata[oam_status_pkg::bit_diag];
			next_utp_down    = pwdata[oam_status_pkg::bit_utp_down];
		end
		if (wr_access && reg_index == oam_status_pkg::idx_status_second)
		begin
			next_multi_if = pwdata[oam_status_pkg::bit_multi_if];
			if (terminal_role)
			begin
				next_autoneg = pwdata[oam_status_pkg::bit_autoneg];
			end
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_count       <= oam_status_pkg::count_reset;
			rx_count       <= oam_status_pkg::count_reset;
			partner_mirror <= oam_status_pkg::mirror_reset_centre;
			loss_select    <= 1'b0;
			diag_result    <= 1'b0;
			utp_down       <= 1'b1;
			multi_if       <= 1'b0;
			autoneg        <= 1'b0;
		end
		else
		begin
			tx_count       <= next_tx_count;
			rx_count       <= next_rx_count;
			partner_mirror <= next_partner_mirror;
			loss_select    <= next_loss_select;
			diag_result    <= next_diag_result;
			utp_down       <= next_utp_down;
			multi_if       <= next_multi_if;
			autoneg        <= next_autoneg;
		end
	end

	// interrupt causes: packet strobes and changes of the two link-down indications
	always_comb
	begin
		irq_events = '0;
		irq_events[oam_status_pkg::irq_bit_tx]  = events.tx_valid_packet;
		irq_events[oam_status_pkg::irq_bit_rx]  = events.rx_valid_packet;
		irq_events[oam_status_pkg::irq_bit_opt] = pins_sync.optical_signal_absent != opt_prev;
		irq_events[oam_status_pkg::irq_bit_utp] = utp_down != utp_prev;
		next_opt_prev = pins_sync.optical_signal_absent;
		next_utp_prev = utp_down;
	end

	// sticky interrupt status, cleared by read; a new event wins over the clear
	always_comb
	begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (rd_access && reg_index == oam_status_pkg::idx_irq_status)
		begin
			next_irq_status = '0;
		end
		next_irq_status = next_irq_status | irq_events;
		if (wr_access && reg_index == oam_status_pkg::idx_irq_mask)
		begin
			next_irq_mask = pwdata[oam_status_pkg::irq_width-1:0];
		end
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_status <= '0;
			irq_mask   <= '0;
			opt_prev   <= 1'b0;
			utp_prev   <= 1'b1;
			irq        <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			opt_prev   <= next_opt_prev;
			utp_prev   <= next_utp_prev;
			irq        <= next_irq;
		end
	end

	// read data registered in the setup cycle, valid in the access phase
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite)
		begin
			case (paddr[oam_status_pkg::addr_lsb +: 8])
				oam_status_pkg::idx_tx_count:       next_prdata[7:0] = tx_count;
				oam_status_pkg::idx_rx_count:       next_prdata[7:0] = rx_count;
				oam_status_pkg::idx_partner_mirror: next_prdata[7:0] = partner_mirror;
				oam_status_pkg::idx_status_first:   next_prdata[7:0] = status_first;
				oam_status_pkg::idx_status_second:  next_prdata[7:0] = status_second;
				oam_status_pkg::idx_irq_status:
					next_prdata[oam_status_pkg::irq_width-1:0] = irq_status | irq_events;
				oam_status_pkg::idx_irq_mask:
					next_prdata[oam_status_pkg::irq_width-1:0] = irq_mask;
				default:                            next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata <= 32'h0000_0000;
		end
		else
		begin
			prdata <= next_prdata;
		end
	end
endmodule

// >>> oam_status_pkg.sv
// Purpose: constants and types shared by the maintenance status/counter bank
// Assumes: 32-bit APB, one register per aligned word
// Notes: printed offsets are register indices; byte address is four times the index
package oam_status_pkg;
	localparam logic [7:0] idx_maint_ctrl      = 8'h44;
	localparam logic [7:0] idx_tx_count        = 8'h4D;
	localparam logic [7:0] idx_rx_count        = 8'h4E;
	localparam logic [7:0] idx_partner_mirror  = 8'h4F;
	localparam logic [7:0] idx_status_first    = 8'h50;
	localparam logic [7:0] idx_status_second   = 8'h51;
	localparam logic [7:0] idx_partner_status  = 8'h58;
	localparam logic [7:0] idx_irq_status      = 8'hF0;
	localparam logic [7:0] idx_irq_mask        = 8'hF1;

	localparam int addr_lsb = 2;

	localparam int bit_role         = 6;
	localparam int bit_loopback     = 5;
	localparam int bit_loss_select  = 4;
	localparam int bit_diag         = 3;
	localparam int bit_utp_down     = 2;
	localparam int bit_opt_absent   = 1;
	localparam int bit_multi_if     = 3;
	localparam int bit_autoneg      = 2;
	localparam int bit_duplex       = 1;
	localparam int bit_speed        = 0;

	localparam logic [7:0] count_reset          = 8'h00;
	localparam logic [7:0] count_clear_value    = 8'h00;
	localparam logic [7:0] mirror_reset_terminal = 8'h07;
	localparam logic [7:0] mirror_reset_centre   = 8'h47;

	localparam int irq_bit_tx       = 0;
	localparam int irq_bit_rx       = 1;
	localparam int irq_bit_opt      = 2;
	localparam int irq_bit_utp      = 3;
	localparam int irq_width        = 4;

	typedef struct packed {
		logic optical_signal_absent;
		logic loss_select_pin;
		logic diagnostic_fail_pin;
		logic utp_link_down;
		logic utp_full_duplex;
		logic utp_speed_100;
		logic autoneg_enable_pin;
	} phy_pins_t;

	typedef struct packed {
		logic       tx_valid_packet;
		logic       rx_valid_packet;
		logic       partner_update;
		logic [7:0] partner_status_byte;
		logic       loopback_active;
	} engine_events_t;
endpackage

// >>> oam_far_end.sv
// Purpose: far-end maintenance engine model driving event strobes
// Assumes: one packet per strobe, each strobe followed by an idle cycle
// Notes: status byte is inverted once each offered update ends; it is zero before the first update
`timescale 1ns/1ps
module oam_far_end
(
	input  wire logic                      clock,
	output oam_status_pkg::engine_events_t events
);
	initial events = '0;
	// only packets with good crc, opcode and direction raise a strobe
	task automatic pulse(input logic tx, input logic rx, input int n);
		repeat (n)
		begin
			@(posedge clock);
			events.tx_valid_packet <= tx;
			events.rx_valid_packet <= rx;
			@(posedge clock);
			events.tx_valid_packet <= 1'b0;
			events.rx_valid_packet <= 1'b0;
		end
	endtask
	// byte carries the local first-status layout
	task automatic update(input logic [7:0] b);
		@(posedge clock);
		events.partner_update <= 1'b1;
		events.partner_status_byte <= b;
		@(posedge clock);
		events.partner_update <= 1'b0;
		events.partner_status_byte <= ~b;
	endtask
	task automatic loop(input logic on);
		@(posedge clock);
		events.loopback_active <= on;
	endtask
endmodule

// >>> oam_status_props.sv
// Purpose: port checks for the status and counter bank
// Assumes: strap held steady outside reset
// Notes: bound to the top module
`timescale 1ns/1ps
module oam_status_props
(
	input wire logic                           clock,
	input wire logic                           nrst,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [11:0]                    paddr,
	input wire logic [31:0]                    pwdata,
	input wire logic [31:0]                    prdata,
	input wire logic                           pready,
	input wire logic                           pslverr,
	input wire logic                           terminal_role_strap,
	input wire oam_status_pkg::phy_pins_t      pins,
	input wire oam_status_pkg::engine_events_t events,
	input wire logic                           irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic       acc_rd;
	logic       at_first;
	logic       at_second;
	logic [2:0] down_run;
	logic [2:0] next_down_run;
	assign acc_rd = psel && penable && !pwrite;
	assign at_first = paddr == {2'h0, oam_status_pkg::idx_status_first, 2'h0};
	assign at_second = paddr == {2'h0, oam_status_pkg::idx_status_second, 2'h0};
	// cycles the link-down pin has stood high, saturating
	always_comb
	begin
		next_down_run = down_run;
		if (!pins.utp_link_down)
			next_down_run = 3'h0;
		else if (down_run != 3'h7)
			next_down_run = down_run + 3'h1;
	end
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			down_run <= 3'h0;
		else
			down_run <= next_down_run;
	end
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	a_err_idle: assert property (!(psel && penable) |-> !pslverr)
		else $error("pslverr outside access");
	a_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
		else $error("prdata not zero outside access");
	a_refused_zero: assert property (acc_rd && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_role_bit: assert property (acc_rd && at_first |-> prdata[6] == terminal_role_strap)
		else $error("role bit does not match strap");
	a_centre_zero: assert property (acc_rd && at_second && !terminal_role_strap |-> prdata[2:0] == 3'h0)
		else $error("centre second status low bits set");
	a_down_quiet: assert property (acc_rd && at_second && down_run >= 3'h5 |-> prdata[1:0] == 2'h0)
		else $error("duplex or speed shown while link down");
	a_down_flag: assert property (acc_rd && at_first && terminal_role_strap && down_run >= 3'h5 |-> prdata[2])
		else $error("link down flag clear while pin high");
endmodule
bind oam_status_counters oam_status_props u_oam_status_props
(
	.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.terminal_role_strap(terminal_role_strap), .pins(pins), .events(events), .irq(irq)
);

// >>> oam_status_counters_tb.sv
// Purpose: self-checking bench for the status and counter bank
// Assumes: byte address is four times the register index
// Notes: centre role first, terminal role after a second reset
`timescale 1ns/1ps
module oam_status_counters_tb;
	logic                           clock = 1'b0;
	logic                           nrst = 1'b0;
	logic                           psel = 1'b0;
	logic                           penable = 1'b0;
	logic                           pwrite = 1'b0;
	logic [11:0]                    paddr = 12'h0;
	logic [31:0]                    pwdata = 32'h0;
	logic [31:0]                    prdata;
	logic                           pready;
	logic                           pslverr;
	logic                           irq;
	logic                           strap = 1'b0;
	oam_status_pkg::phy_pins_t      pins = 7'h4F;
	oam_status_pkg::engine_events_t events;
	logic [31:0]                    rd_data;
	logic                           rd_err;
	int                             bad_count = 0;
	int                             checks = 0;
	int                             cycles = 0;
	always #2.5 clock = ~clock;
	oam_far_end u_oam_far_end (.clock(clock), .events(events));
	oam_status_counters u_oam_status_counters
	(
		.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.terminal_role_strap(strap), .pins(pins), .events(events), .irq(irq)
	);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, {2'h0, i, 2'h0}, {24'h0, d});
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, {2'h0, i, 2'h0}, 32'h0);
		chk($sformatf("reg %h", i), {24'h0, e}, rd_data);
	endtask
	task automatic do_reset(input logic s, input logic [6:0] p);
		@(posedge clock);
		nrst <= 1'b0;
		strap <= s;
		pins <= p;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
	endtask
	task automatic t_reset;
		rd(8'h4D, 8'h00);
		rd(8'h4E, 8'h00);
		rd(8'h4F, 8'h47);
		rd(8'h50, 8'h06);
		rd(8'h51, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_count;
		u_oam_far_end.pulse(1'b1, 1'b0, 3);
		u_oam_far_end.pulse(1'b0, 1'b1, 2);
		wr(8'h44, 8'h01);
		wr(8'h4D, 8'hFF);
		rd(8'h4D, 8'h03);
		rd(8'h4E, 8'h02);
		wr(8'h44, 8'h00);
		rd(8'h4D, 8'h00);
		rd(8'h4E, 8'h00);
		u_oam_far_end.pulse(1'b1, 1'b1, 257);
		rd(8'h4D, 8'h01);
		rd(8'h4E, 8'h01);
		$display("counter test done");
	endtask
	task automatic t_mirror;
		pins.optical_signal_absent <= 1'b0;
		repeat (4) @(posedge clock);
		u_oam_far_end.update(8'h5A);
		rd(8'h4F, 8'h5A);
		rd(8'h50, 8'h04);
		pins.optical_signal_absent <= 1'b1;
		repeat (4) @(posedge clock);
		u_oam_far_end.update(8'h33);
		rd(8'h4F, 8'h5A);
		$display("mirror test done");
	endtask
	task automatic t_centre;
		wr(8'h50, 8'hF9);
		rd(8'h50, 8'h1A);
		wr(8'h51, 8'hFF);
		rd(8'h51, 8'h08);
		u_oam_far_end.loop(1'b1);
		rd(8'h50, 8'h3A);
		u_oam_far_end.loop(1'b0);
		rd(8'h50, 8'h1A);
		$display("centre test done");
	endtask
	task automatic t_irq;
		wr(8'hF1, 8'h01);
		apb(1'b0, 12'h3C0, 32'h0);
		repeat (3) @(negedge clock);
		chk("irq idle", 32'h0, {31'h0, irq});
		u_oam_far_end.pulse(1'b0, 1'b1, 1);
		repeat (3) @(negedge clock);
		chk("irq masked", 32'h0, {31'h0, irq});
		u_oam_far_end.pulse(1'b1, 1'b0, 1);
		repeat (3) @(negedge clock);
		chk("irq raised", 32'h1, {31'h0, irq});
		rd(8'hF0, 8'h03);
		repeat (3) @(negedge clock);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apb(1'b0, 12'h004, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rd_err});
		chk("unmapped data", 32'h0, rd_data);
		apb(1'b1, 12'h135, 32'h0);
		chk("misaligned err", 32'h1, {31'h0, rd_err});
		$display("interrupt and refusal test done");
	endtask
	task automatic t_terminal;
		do_reset(1'b1, 7'h77);
		rd(8'h50, 8'h5A);
		rd(8'h4F, 8'h07);
		rd(8'h51, 8'h07);
		wr(8'h50, 8'h00);
		rd(8'h50, 8'h5A);
		pins.utp_link_down <= 1'b1;
		repeat (6) @(posedge clock);
		rd(8'h50, 8'h5E);
		rd(8'h51, 8'h04);
		$display("terminal test done");
	endtask
	initial
	begin
		do_reset(1'b0, 7'h4F);
		t_reset();
		t_count();
		t_mirror();
		t_centre();
		t_irq();
		t_terminal();
		complete_run();
	end
endmodule
